// *** hw/dao_pkg.sv ***
package dao_pkg;
  // ****************************************************************
  // sizes and timing
  // ****************************************************************
  localparam int CLK_MHZ     = 125;
  localparam int DAT_W       = 12;
  localparam int CH_W        = 13;
  localparam int N_CH        = 2;
  localparam int WORD_W      = N_CH * CH_W;
  localparam int LAT         = 9;
  localparam int FIFO_D      = 32;
  localparam int DCS_MIN_MHZ = 20;
  localparam int DCS_MAX_PER = CLK_MHZ / DCS_MIN_MHZ;
  localparam int RELOCK_NS   = 1500;
  localparam int RELOCK_CYC  = (RELOCK_NS * CLK_MHZ + 999) / 1000;
  localparam int STBY_WAKE   = 16;
  localparam int WAKE_SH     = 4;
  localparam int DWELL_W     = 20;
  localparam int PER_W       = 8;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_PWR   = 8'h04;
  localparam logic [7:0] A_CHSEL = 8'h08;
  localparam logic [7:0] A_STAT  = 8'h0C;
  localparam logic [7:0] A_OUTM  = 8'h14;
  localparam int C_SER  = 0;
  localparam int C_DCS  = 1;
  localparam int C_MUX  = 2;
  localparam int C_INV  = 3;
  localparam int C_HOLD = 4;
  localparam int OM_OD  = 4;
  localparam int S_OVF  = 0;
  localparam int S_LOCK = 1;
  localparam int S_SLOW = 2;
  localparam int S_RUN  = 3;
  localparam int S_LVL  = 8;
  localparam logic [4:0] CTRL_RST  = 5'h00;
  localparam logic [1:0] CHSEL_RST = 2'h3;
  typedef enum logic [1:0] {FMT_OFFS = 2'b00, FMT_TWOS = 2'b01, FMT_GRAY = 2'b10} dao_fmt_t;
  typedef enum logic [1:0] {PM_RUN = 2'b00, PM_PD = 2'b01, PM_STBY = 2'b10} dao_pm_t;
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_POWER_DOWN_PIN = 2'b01,
    ST_STBY = 2'b10,
    ST_WAKE = 2'b11
  } dao_st_t;
endpackage

// *** hw/dao_top.sv ***
`timescale 1ns/100ps
module dao_fifo #(
  parameter int W     = 26,
  parameter int DEPTH = 32,
  localparam int AW   = $clog2(DEPTH)
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        level
);
  logic [W-1:0] mem_r [DEPTH];
  logic [AW:0]  wp_r;
  logic [AW:0]  rp_r;
  wire          push_w = in_valid & in_ready;
  wire          pop_w  = out_valid & out_ready;

  assign level     = wp_r - rp_r;
  assign in_ready  = level != (AW+1)'(DEPTH);
  assign out_valid = level != '0;
  assign out_data  = mem_r[rp_r[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push_w) begin
      mem_r[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push_w) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop_w) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

module dao_top
  import dao_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              sample_clk,
  input  wire logic [DAT_W-1:0]  adc_a_code,
  input  wire logic              adc_a_ovr,
  input  wire logic [DAT_W-1:0]  adc_b_code,
  input  wire logic              adc_b_ovr,
  input  wire logic              output_disable,
  input  wire logic              power_down_pin,
  input  wire logic              format_select_pin,
  input  wire logic              stabilizer_select_pin,
  output logic [CH_W-1:0]        data_a,
  output logic                   data_a_oe,
  output logic [CH_W-1:0]        data_b,
  output logic                   data_b_oe,
  output logic                   data_clock_out_a,
  output logic                   data_clock_out_a_oe,
  output logic                   data_clock_out_b,
  output logic                   data_clock_out_b_oe
);
  localparam int SY_W = 5 + WORD_W;
  localparam int LV_W = $clog2(FIFO_D) + 1;
  localparam int RL_W = $clog2(RELOCK_CYC + 1);

  function automatic logic [DAT_W-1:0] fmt_fn(input logic [DAT_W-1:0] b,
                                               input logic [1:0] f);
    logic [DAT_W-1:0] t;
    t = b;
    case (f)
      FMT_TWOS: t = {~b[DAT_W-1], b[DAT_W-2:0]};
      FMT_GRAY: t = b ^ (b >> 1);
      default:  t = b;
    endcase
    return t;
  endfunction

  // ****************************************************************
  // pin synchronisers and sample clock edges
  // ****************************************************************
  logic [SY_W-1:0] sy1_r;
  logic [SY_W-1:0] sy2_r;
  logic            clk_d_r;
  wire [SY_W-1:0]  sy_in_w = {sample_clk, output_disable, power_down_pin,
                              format_select_pin, stabilizer_select_pin,
                              adc_a_ovr, adc_a_code, adc_b_ovr, adc_b_code};
  wire             sclk_w     = sy2_r[SY_W-1];
  wire             od_pin_w   = sy2_r[SY_W-2];
  wire             pd_pin_w   = sy2_r[SY_W-3];
  wire             dfs_pin_w  = sy2_r[SY_W-4];
  wire             dcs_pin_w  = sy2_r[SY_W-5];
  wire [WORD_W-1:0] in_word_w = sy2_r[WORD_W-1:0];
  wire             rise_w     = sclk_w & ~clk_d_r;
  wire             sfall_w    = ~sclk_w & clk_d_r;

  always_ff @(posedge mclk) begin
    sy1_r   <= sy_in_w;
    sy2_r   <= sy1_r;
    clk_d_r <= sclk_w;
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [4:0]  ctrl_r;
  logic [1:0]  pwr_r;
  logic [1:0]  chsel_r;
  logic [1:0]  fmt_r;
  logic [1:0]  od_r;
  logic        ovf_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;
  logic        lock_r;
  dao_st_t     st_r;
  logic [LV_W-1:0] lvl_w;
  logic        in_rdy_w;

  wire ser_w  = ctrl_r[C_SER];
  wire mux_w  = ctrl_r[C_MUX];
  wire hold_w = ctrl_r[C_HOLD];
  wire run_w  = st_r == ST_RUN;
  wire dcs_en_w = ser_w ? ctrl_r[C_DCS] : dcs_pin_w;
  wire [1:0] fmt_w = ser_w ? fmt_r : (dfs_pin_w ? FMT_TWOS : FMT_OFFS);
  wire setup_w = psel & ~penable;
  wire hit_w   = paddr == A_CTRL || paddr == A_PWR || paddr == A_CHSEL ||
                 paddr == A_STAT || paddr == A_OUTM;
  wire wr_w    = psel & penable & pwrite & pready_r & hit_w;
  wire push_w  = rise_w & run_w;
  wire ovf_set_w = push_w & ~in_rdy_w;
  wire slow_w;
  wire od_sel_w  = chsel_r[0] ? od_r[0] : od_r[1];
  wire [31:0] stat_w = (32'(lvl_w) << S_LVL) | (32'(run_w) << S_RUN) |
                       (32'(slow_w) << S_SLOW) | (32'(lock_r) << S_LOCK) |
                       (32'(ovf_r) << S_OVF);
  wire [31:0] rd_w = (paddr == A_CTRL)  ? 32'(ctrl_r) :
                     (paddr == A_PWR)   ? 32'(pwr_r) :
                     (paddr == A_CHSEL) ? 32'(chsel_r) :
                     (paddr == A_STAT)  ? stat_w :
                     (paddr == A_OUTM)  ? ((32'(od_sel_w) << OM_OD) | 32'(fmt_r)) :
                     32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_w) begin
        prdata_r  <= rd_w;
        pslverr_r <= ~hit_w;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r  <= CTRL_RST;
      pwr_r   <= PM_RUN;
      chsel_r <= CHSEL_RST;
      fmt_r   <= FMT_OFFS;
    end else if (wr_w) begin
      if (paddr == A_CTRL) ctrl_r <= pwdata[4:0];
      if (paddr == A_PWR) pwr_r <= pwdata[1:0];
      if (paddr == A_CHSEL) chsel_r <= pwdata[1:0];
      if (paddr == A_OUTM) fmt_r <= pwdata[1:0];
    end
  end

  // overflow is sticky; a new overflow wins over a clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= ovf_set_w | (ovf_r & ~(wr_w && paddr == A_STAT && pwdata[S_OVF]));
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_od
      always_ff @(posedge mclk) begin
        if (reset) begin
          od_r[gc] <= 1'b0;
        end else if (wr_w && paddr == A_OUTM && chsel_r[gc]) begin
          od_r[gc] <= pwdata[OM_OD];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // power modes
  // ****************************************************************
  logic [DWELL_W-1:0] dwell_r;
  logic [DWELL_W-1:0] wake_r;
  wire pd_req_w = pd_pin_w | (pwr_r == PM_PD);
  wire sb_req_w = pwr_r == PM_STBY;

  always_ff @(posedge mclk) begin
    if (reset) begin
      st_r    <= ST_RUN;
      dwell_r <= '0;
      wake_r  <= '0;
    end else begin
      case (st_r)
        ST_RUN: begin
          dwell_r <= '0;
          if (pd_req_w) st_r <= ST_POWER_DOWN_PIN;
          else if (sb_req_w) st_r <= ST_STBY;
        end
        ST_POWER_DOWN_PIN: begin
          if (~&dwell_r) dwell_r <= dwell_r + 1'b1;
          if (!pd_req_w) begin
            st_r   <= ST_WAKE;
            wake_r <= dwell_r >> WAKE_SH;
          end
        end
        ST_STBY: begin
          if (pd_req_w) st_r <= ST_POWER_DOWN_PIN;
          else if (!sb_req_w) begin
            st_r   <= ST_WAKE;
            wake_r <= DWELL_W'(STBY_WAKE);
          end
        end
        ST_WAKE: begin
          if (pd_req_w) st_r <= ST_POWER_DOWN_PIN;
          else if (wake_r == '0) st_r <= ST_RUN;
          else wake_r <= wake_r - 1'b1;
        end
        default: st_r <= ST_RUN;
      endcase
    end
  end

  // ****************************************************************
  // duty cycle stabilizer
  // ****************************************************************
  logic [PER_W-1:0] cnt_r;
  logic [PER_W-1:0] per_r;
  logic [RL_W-1:0]  rl_r;
  wire [PER_W-1:0]  new_per_w = cnt_r + 1'b1;
  wire [PER_W-1:0]  half_w    = per_r >> 1;
  wire stable_w = new_per_w == per_r || new_per_w == per_r + 1'b1 ||
                  new_per_w + 1'b1 == per_r;
  assign slow_w = per_r > PER_W'(DCS_MAX_PER) || &cnt_r;
  wire dcs_on_w = dcs_en_w & lock_r & ~slow_w;
  wire fall_w   = dcs_on_w ? (cnt_r == half_w && !rise_w) : sfall_w;
  wire iclk_w   = dcs_on_w ? (rise_w | (cnt_r < half_w)) : sclk_w;

  always_ff @(posedge mclk) begin
    if (reset) begin
      cnt_r  <= '0;
      per_r  <= '1;
      rl_r   <= '0;
      lock_r <= 1'b0;
    end else begin
      if (rise_w) begin
        cnt_r <= '0;
        per_r <= new_per_w;
      end else if (~&cnt_r) begin
        cnt_r <= cnt_r + 1'b1;
      end
      if ((rise_w && !stable_w) || slow_w) begin
        rl_r   <= '0;
        lock_r <= 1'b0;
      end else if (rl_r == RL_W'(RELOCK_CYC)) begin
        lock_r <= 1'b1;
      end else begin
        rl_r <= rl_r + 1'b1;
      end
    end
  end

  // ****************************************************************
  // nine-edge pipeline buffer and output stage
  // ****************************************************************
  logic [WORD_W-1:0] f_out_w;
  logic [WORD_W-1:0] word_r;
  logic [CH_W-1:0]   dat_r [N_CH];
  logic [N_CH-1:0]   en_r;
  logic              dco_r;
  logic              iclk_d_r;
  wire pop_w = rise_w & run_w & ~hold_w & (lvl_w >= LV_W'(LAT));

  dao_fifo #(.W(WORD_W), .DEPTH(FIFO_D)) u_fifo (
    .clk       (mclk),
    .rst       (reset | ~run_w),
    .in_valid  (push_w),
    .in_ready  (in_rdy_w),
    .in_data   (in_word_w),
    .out_valid (),
    .out_ready (pop_w),
    .out_data  (f_out_w),
    .level     (lvl_w)
  );

  always_ff @(posedge mclk) begin
    if (reset) begin
      word_r   <= '0;
      dco_r    <= 1'b0;
      iclk_d_r <= 1'b0;
    end else begin
      if (pop_w) word_r <= f_out_w;
      iclk_d_r <= iclk_w;
      dco_r    <= (mux_w ? iclk_d_r : ~iclk_w) ^ ctrl_r[C_INV];
    end
  end

  generate
    for (gc = 0; gc < N_CH; gc++) begin : g_ch
      wire bsel_w = (gc == 0) && mux_w && fall_w && !pop_w;
      wire [CH_W-1:0] src_w = bsel_w ? word_r[CH_W-1:0] :
                              f_out_w[(N_CH-gc)*CH_W-1 -: CH_W];
      wire [CH_W-1:0] code_w = {src_w[DAT_W], fmt_fn(src_w[DAT_W-1:0], fmt_w)};
      wire en_w = run_w & ~od_pin_w & ~od_r[gc] & ~((gc == 1) && mux_w);
      always_ff @(posedge mclk) begin
        if (reset) begin
          dat_r[gc] <= '0;
          en_r[gc]  <= 1'b0;
        end else begin
          en_r[gc] <= en_w;
          if (pop_w || bsel_w) dat_r[gc] <= code_w;
        end
      end
    end
  endgenerate

  assign prdata              = prdata_r;
  assign pready              = pready_r;
  assign pslverr             = pslverr_r;
  assign data_a              = dat_r[0];
  assign data_b              = dat_r[1];
  assign data_a_oe           = en_r[0];
  assign data_b_oe           = en_r[1];
  assign data_clock_out_a    = dco_r;
  assign data_clock_out_b    = dco_r;
  assign data_clock_out_a_oe = en_r[0];
  assign data_clock_out_b_oe = en_r[1];

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_lat;
    (rise_w && run_w && !hold_w && lvl_w == LV_W'(LAT)) |=>
      data_a[DAT_W] == $past(f_out_w[WORD_W-1]);
  endproperty
  a_lat: assert property (p_lat) else $error("latency pop missed");
  property p_drive;
    (run_w && !od_pin_w && !od_r[0]) |=> data_a_oe && data_clock_out_a_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("outputs not driven");
  property p_hiz;
    od_pin_w |=> !data_a_oe && !data_clock_out_b_oe;
  endproperty
  a_hiz: assert property (p_hiz) else $error("disable pin ignored");
  property p_chod;
    od_r[1] |=> !data_b_oe && !data_clock_out_b_oe;
  endproperty
  a_chod: assert property (p_chod) else $error("channel disable ignored");
  property p_pd;
    pd_pin_w |-> ##1 st_r == ST_POWER_DOWN_PIN ##1 !data_a_oe;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down not entered");
  property p_pdz;
    !run_w |=> !data_clock_out_a_oe && !data_b_oe;
  endproperty
  a_pdz: assert property (p_pdz) else $error("driver active when down");
  property p_wake;
    (st_r == ST_WAKE && wake_r == '0 && !pd_req_w) |=> run_w;
  endproperty
  a_wake: assert property (p_wake) else $error("wake did not finish");
  property p_stby;
    (st_r == ST_STBY && !pd_req_w && !sb_req_w) |=>
      st_r == ST_WAKE && wake_r == DWELL_W'(STBY_WAKE);
  endproperty
  a_stby: assert property (p_stby) else $error("standby wake wrong");
  property p_fmt;
    (!ser_w && dfs_pin_w) |-> fmt_w == FMT_TWOS;
  endproperty
  a_fmt: assert property (p_fmt) else $error("format pin ignored");
  property p_slow;
    slow_w |-> !dcs_on_w;
  endproperty
  a_slow: assert property (p_slow) else $error("stabilizer on at low rate");
  property p_mux;
    (mux_w && fall_w && !pop_w) |=> data_a[DAT_W] == $past(word_r[DAT_W]);
  endproperty
  a_mux: assert property (p_mux) else $error("channel B not on shared bus");
  c_mux:  cover property (mux_w && fall_w && run_w);
  c_pd:   cover property (st_r == ST_WAKE ##1 run_w);
  c_lock: cover property ($rose(lock_r));
endmodule

// *** test/dao_cap.sv ***
`timescale 1ns/100ps
// ****************************************************************
// capture register clocked by mclk, loading on edges of the forwarded data clock
// ****************************************************************
module dao_cap
  import dao_pkg::*;
(
  input  wire logic            mclk,
  input  wire logic            inv,
  input  wire logic [CH_W-1:0] data,
  input  wire logic            data_oe,
  input  wire logic            dco,
  input  wire logic            dco_oe,
  output logic      [CH_W-1:0] word_r
);
  logic [CH_W-1:0] bus;
  logic            dclk;
  logic            dclk_r;
  logic            edge_hit;
  logic            dco_last_r = 1'b0;
  // released data lines show the inverse of the device's data; a released clock line the inverse of its last driven level
  assign bus      = data_oe ? data : ~data;
  assign dclk     = dco_oe ? dco : ~dco_last_r;
  assign edge_hit = inv ? (dclk_r & ~dclk) : (~dclk_r & dclk);
  always @(posedge mclk) begin
    dclk_r <= dclk;
    if (dco_oe) begin
      dco_last_r <= dco;
    end
    if (edge_hit) begin
      word_r <= bus;
    end
  end
endmodule

// *** test/dao_top_tb.sv ***
`timescale 1ns/100ps
module dao_top_tb
  import dao_pkg::*;
;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic [7:0]        paddr = 8'h00;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              sample_clk = 1'b0;
  logic [DAT_W-1:0]  a_code = 12'h000;
  logic              a_ovr = 1'b0;
  logic [DAT_W-1:0]  b_code = 12'h000;
  logic              b_ovr = 1'b0;
  logic              output_disable = 1'b0;
  logic              power_down_pin = 1'b0;
  logic              format_select_pin = 1'b0;
  logic              stabilizer_select_pin = 1'b0;
  logic [CH_W-1:0]   data_a;
  logic [CH_W-1:0]   data_b;
  logic              a_oe;
  logic              b_oe;
  logic              dco_a;
  logic              dco_b;
  logic              dco_a_oe;
  logic              dco_b_oe;
  logic              inv = 1'b0;
  logic [CH_W-1:0]   cap_word;
  logic [31:0]       rd;
  logic              er;
  logic [31:0]       seed = 32'h5935;
  int                errors = 0;
  int                check_count = 0;
  int                cyc = 0;
  int                n;
  // ****************************************************************
  // clocks, partner and device
  // ****************************************************************
  always #4 mclk = ~mclk;
  always #62.5 sample_clk = ~sample_clk;
  dao_cap i_cap (.mclk(mclk), .inv(inv), .data(data_a), .data_oe(a_oe), .dco(dco_a),
                 .dco_oe(dco_a_oe), .word_r(cap_word));
  dao_top i_dut (
    .mclk(mclk), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_clk(sample_clk), .adc_a_code(a_code), .adc_a_ovr(a_ovr), .adc_b_code(b_code),
    .adc_b_ovr(b_ovr), .output_disable(output_disable), .power_down_pin(power_down_pin),
    .format_select_pin(format_select_pin), .stabilizer_select_pin(stabilizer_select_pin),
    .data_a(data_a), .data_a_oe(a_oe), .data_b(data_b), .data_b_oe(b_oe),
    .data_clock_out_a(dco_a), .data_clock_out_a_oe(dco_a_oe), .data_clock_out_b(dco_b),
    .data_clock_out_b_oe(dco_b_oe));
  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] xs(logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [12:0] fx(logic [11:0] c, logic o, int f);
    case (f)
      1: return {o, c ^ 12'h800};
      2: return {o, c ^ (c >> 1)};
      default: return {o, c};
    endcase
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic swait(int k);
    repeat (k) @(posedge sample_clk);
    repeat (8) @(posedge mclk);
  endtask
  task automatic drive(logic [11:0] ca, logic oa, logic [11:0] cb, logic ob);
    @(posedge mclk);
    a_code <= ca;
    a_ovr <= oa;
    b_code <= cb;
    b_ovr <= ob;
  endtask
  task automatic fmt_run(int f);
    logic [11:0] tbl [3];
    tbl = '{12'h000, 12'h800, 12'hFFF};
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      drive(i < 3 ? tbl[i] : seed[11:0], seed[12], seed[27:16], seed[28]);
      swait(12);
      chk(data_a, fx(a_code, a_ovr, f));
      chk(data_b, fx(b_code, b_ovr, f));
      chk({dco_a, dco_b}, 2'h0);
    end
  endtask
  task automatic wake(output int k);
    k = 0;
    while (a_oe !== 1'b1 && k < 2000) begin
      @(posedge mclk);
      k++;
    end
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      close_out();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge mclk);
    chk({a_oe, b_oe, dco_a_oe, dco_b_oe}, 4'h0);
    reset <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0);
    chk(rd, {27'h0, CTRL_RST});
    apb(1'b0, A_CHSEL, 32'h0);
    chk(rd, {30'h0, CHSEL_RST});
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    // pipeline depth measured in sample clocks
    seed = xs(seed);
    drive(seed[11:0], 1'b0, seed[23:12], 1'b0);
    swait(12);
    @(posedge sample_clk);
    seed = xs(seed);
    drive(seed[11:0], 1'b1, seed[23:12], 1'b0);
    repeat (9) @(posedge sample_clk);
    repeat (8) @(posedge mclk);
    chk(data_a[12], 1'b0);
    swait(1);
    chk(data_a, fx(a_code, 1'b1, 0));
    for (int f = 0; f < 2; f++) begin
      format_select_pin <= f[0];
      fmt_run(f);
    end
    apb(1'b1, A_CTRL, 32'h1);
    for (int f = 0; f < 4; f++) begin
      apb(1'b1, A_OUTM, f);
      fmt_run(f == 3 ? 0 : f);
    end
    chk(cap_word, fx(a_code, a_ovr, 0));
    inv <= 1'b1;
    apb(1'b1, A_CTRL, 32'h9);
    seed = xs(seed);
    drive(seed[11:0], seed[12], seed[27:16], seed[28]);
    swait(12);
    chk(cap_word, fx(a_code, a_ovr, 0));
    chk({dco_a, dco_b}, 2'h3);
    inv <= 1'b0;
    apb(1'b1, A_CTRL, 32'h5);
    swait(12);
    chk({dco_b_oe, b_oe}, 2'h0);
    chk(cap_word, fx(a_code, a_ovr, 0));
    inv <= 1'b1;
    swait(2);
    chk(cap_word, fx(b_code, b_ovr, 0));
    inv <= 1'b0;
    apb(1'b1, A_CTRL, 32'h3);
    stabilizer_select_pin <= 1'b1;
    output_disable <= 1'b1;
    repeat (10) @(posedge mclk);
    chk({a_oe, b_oe, dco_a_oe, dco_b_oe}, 4'h0);
    output_disable <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({a_oe, b_oe, dco_a_oe, dco_b_oe}, 4'hF);
    apb(1'b1, A_CHSEL, 32'h1);
    apb(1'b1, A_OUTM, 32'h10);
    repeat (4) @(posedge mclk);
    chk({a_oe, dco_a_oe, b_oe, dco_b_oe}, 4'h3);
    apb(1'b1, A_CHSEL, 32'h3);
    apb(1'b1, A_OUTM, 32'h0);
    apb(1'b1, A_CHSEL, 32'h2);
    apb(1'b1, A_OUTM, 32'h10);
    apb(1'b0, A_OUTM, 32'h0);
    chk(rd, 32'h10);
    chk({a_oe, dco_a_oe, b_oe, dco_b_oe}, 4'hC);
    apb(1'b1, A_CHSEL, 32'h3);
    apb(1'b1, A_OUTM, 32'h0);
    power_down_pin <= 1'b1;
    repeat (2000) @(posedge mclk);
    chk({a_oe, b_oe, dco_a_oe, dco_b_oe}, 4'h0);
    power_down_pin <= 1'b0;
    wake(n);
    chk(n >= 120 && n <= 220, 1'b1);
    apb(1'b1, A_PWR, 32'h1);
    repeat (4) @(posedge mclk);
    chk(a_oe, 1'b0);
    apb(1'b1, A_PWR, 32'h2);
    repeat (200) @(posedge mclk);
    chk({a_oe, dco_b_oe}, 2'h0);
    apb(1'b1, A_PWR, 32'h0);
    wake(n);
    chk(n <= 30, 1'b1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[S_SLOW], 1'b1);
    // stall draining until the buffer refuses
    apb(1'b1, A_CTRL, 32'h11);
    swait(40);
    apb(1'b0, A_STAT, 32'h0);
    chk({rd[13:8], rd[S_OVF]}, {6'h20, 1'b1});
    apb(1'b1, A_CTRL, 32'h1);
    swait(40);
    apb(1'b1, A_STAT, 32'h1);
    apb(1'b0, A_STAT, 32'h0);
    chk(rd[S_OVF], 1'b0);
    close_out();
  end
endmodule
